// File: src/apr_pkg.sv
// Shared constants and types of the audio port receiver
package apr_pkg;

  // Register map
  localparam logic [7:0] APR_CTRL_ADDR  = 8'h03;
  localparam logic [7:0] APR_STAT_ADDR  = 8'h0F;
  localparam logic [7:0] APR_CTRL_RESET = 8'h04;

  // Control register fields
  localparam int APR_FMT_LSB   = 0;
  localparam int APR_LEN24_BIT = 2;

  // Status register fields
  localparam int APR_ST_PLAY = 0;
  localparam int APR_ST_OVF  = 1;
  localparam int APR_ST_BOK  = 2;
  localparam int APR_ST_MOK  = 3;

  // Framings selected by the control register
  typedef enum logic [1:0] {
    FMT_STANDARD = 2'b00,
    FMT_LEFT     = 2'b01,
    FMT_RIGHT    = 2'b10,
    FMT_TDM      = 2'b11
  } apr_fmt_type;

  // Clock health of the port
  typedef enum logic {
    HEALTH_MUTED = 1'b0,
    HEALTH_PLAY  = 1'b1
  } apr_health_type;

  // Word lengths
  localparam logic [4:0] APR_LEN_SHORT = 5'h10;
  localparam logic [4:0] APR_LEN_LONG  = 5'h18;
  localparam int         APR_SAMPLE_W  = 24;
  localparam int         APR_LANES     = 2;

  // Legal bit clocks per frame, and master clocks per frame
  localparam logic [8:0] APR_BPF_LO     = 9'h020;
  localparam logic [8:0] APR_BPF_HI     = 9'h040;
  localparam logic [8:0] APR_BPF_TDM_LO = 9'h080;
  localparam logic [8:0] APR_BPF_TDM_HI = 9'h100;
  localparam logic [9:0] APR_MPF_A      = 10'h080;
  localparam logic [9:0] APR_MPF_B      = 10'h100;
  localparam logic [9:0] APR_MPF_C      = 10'h200;

  // Halt detection time
  localparam int APR_CLK_MHZ  = 50;
  localparam int APR_HALT_US  = 50;
  localparam int APR_HALT_CYC = APR_HALT_US * APR_CLK_MHZ;

  // Latency ceilings in frames, and FIFO depth in words
  localparam int APR_LAT_FRAMES    = 30;
  localparam int APR_LAT_FRAMES_HI = 12;
  localparam int APR_FIFO_DEPTH    = 16;

  // One captured word, both data lanes
  typedef struct packed {
    logic                                     right;
    logic [APR_LANES-1:0][APR_SAMPLE_W-1:0]   data;
  } apr_word_type;

endpackage

// File: src/apr_sync.sv
// Two-flop synchroniser for levels and quasi-static words
`timescale 1ns/1ps
module apr_sync #(
  parameter int W = 1
) (
  input  wire  logic         clk,
  input  wire  logic         arst_n,
  input  wire  logic [W-1:0] d,
  output logic       [W-1:0] q
);

  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// File: src/apr_fifo.sv
// Dual-clock FIFO with gray-coded pointers
`timescale 1ns/1ps
module apr_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire  logic         wr_clk,
  input  wire  logic         rd_clk,
  input  wire  logic         arst_n,
  input  wire  logic         wr_valid,
  output logic               wr_ready,
  input  wire  logic [W-1:0] wr_data,
  output logic               rd_valid,
  input  wire  logic         rd_ready,
  output logic       [W-1:0] rd_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin;
  logic [AW:0]  rbin;
  logic [AW:0]  wgray;
  logic [AW:0]  rgray;
  logic [AW:0]  wgray_rd;
  logic [AW:0]  rgray_wr;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  // Pointer arithmetic and flags
  wire         push      = wr_valid && wr_ready;
  wire         pop       = rd_valid && rd_ready;
  wire [AW:0]  next_wbin = wbin + {{AW{1'b0}}, push};
  wire [AW:0]  next_rbin = rbin + {{AW{1'b0}}, pop};
  assign wr_ready = wgray != {~rgray_wr[AW:AW-1], rgray_wr[AW-2:0]};
  assign rd_valid = rgray != wgray_rd;
  assign rd_data  = mem[rbin[AW-1:0]];

  // Storage, no reset needed
  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wbin[AW-1:0]] <= wr_data;
    end
  end

  // Write pointer
  always_ff @(posedge wr_clk or negedge arst_n) begin
    if (!arst_n) begin
      wbin  <= '0;
      wgray <= '0;
    end else begin
      wbin  <= next_wbin;
      wgray <= to_gray(next_wbin);
    end
  end

  // Read pointer
  always_ff @(posedge rd_clk or negedge arst_n) begin
    if (!arst_n) begin
      rbin  <= '0;
      rgray <= '0;
    end else begin
      rbin  <= next_rbin;
      rgray <= to_gray(next_rbin);
    end
  end

  // Pointer crossings
  apr_sync #(.W(AW+1)) u_w2r (
    .clk    (rd_clk),
    .arst_n (arst_n),
    .d      (wgray),
    .q      (wgray_rd)
  );
  apr_sync #(.W(AW+1)) u_r2w (
    .clk    (wr_clk),
    .arst_n (arst_n),
    .d      (rgray),
    .q      (rgray_wr)
  );

endmodule

// File: src/apr_receiver.sv
// Serial audio port receiver: capture, clock checks, registers
// What this block does
// - Accepts standard, left-justified, right-justified and multiplexed framings.
// - Port configuration lives in a writable control register at 0x03.
// - Standard framing: frame sync low is left word, high is right.
// - Standard framing: first bit after a sync edge is skipped.
// - Samples arrive MSB first in two's complement, read as signed.
// - Standard framing samples data on bit clock rising edges.
// - Left-justified: frame sync high is left, low is right.
// - Left-justified: MSB arrives in the same period as the sync edge.
// - Left-justified: MSB first, each bit taken on rising edges.
// - Words are 16 or 24 bits; trailing zero padding is ignored.
// - Input to output delay stays within 30 frames, 12 at 96 kHz.
// - Bad clock ratio or halted clock forces outputs high impedance.
`timescale 1ns/1ps
module apr_receiver
  import apr_pkg::*;
#(
  parameter int FIFO_DEPTH = APR_FIFO_DEPTH,
  parameter int HALT_CYC   = APR_HALT_CYC
) (
  input  wire  logic         clk,
  input  wire  logic         arst_n,
  input  wire  logic         bit_clk,
  input  wire  logic         master_clk,
  input  wire  logic         frame_sync,
  input  wire  logic         serial_data_in_one,
  input  wire  logic         serial_data_in_two,
  input  wire  logic [7:0]   reg_addr,
  input  wire  logic [7:0]   reg_wdata,
  input  wire  logic         reg_wr,
  input  wire  logic         reg_rd,
  output logic       [7:0]   reg_rdata,
  output apr_word_type       sample,
  output logic               sample_valid,
  input  wire  logic         sample_ready,
  output logic               channels_hiz
);

  localparam int WW = $bits(apr_word_type);

  // Sign extension of a short word
  function automatic logic [23:0] sext(input logic [23:0] w,
                                       input logic        long_w);
    sext = long_w ? w : {{8{w[15]}}, w[15:0]};
  endfunction

  // ---------------- System clock domain ----------------
  logic [7:0]     audio_port_control;
  logic           ovf_sticky;
  apr_health_type health;
  logic [4:0]     evt_sync;
  logic [4:0]     evt_last;
  logic [11:0]    halt_cnt [2];
  logic           halted [2];

  // Bit-clock and master-clock domain signals used across
  logic           bclk_ok;
  logic           frame_tgl;
  logic           ovf_tgl;
  logic           mclk_ok;
  logic           mframe_tgl;

  // Synchronised flags: 0 bit ok, 1 master ok, 2..4 toggles
  apr_sync #(.W(5)) u_evt_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({ovf_tgl, mframe_tgl, frame_tgl, mclk_ok, bclk_ok}),
    .q      (evt_sync)
  );

  // Event edges and health decode
  wire frame_seen  = evt_sync[2] ^ evt_last[2];
  wire mframe_seen = evt_sync[3] ^ evt_last[3];
  wire ovf_seen    = evt_sync[4] ^ evt_last[4];
  wire clocks_good = evt_sync[0] && evt_sync[1] && !halted[0] && !halted[1];
  wire ctrl_wr     = reg_wr && (reg_addr == APR_CTRL_ADDR);
  wire stat_wr     = reg_wr && (reg_addr == APR_STAT_ADDR);
  wire ovf_clr     = stat_wr && reg_wdata[APR_ST_OVF];
  wire [1:0] seen  = {mframe_seen, frame_seen};
  wire [7:0] stat_word = {4'h0, evt_sync[1], evt_sync[0], ovf_sticky,
                          health == HEALTH_PLAY};
  wire [7:0] next_rdata = (reg_addr == APR_CTRL_ADDR) ? audio_port_control :
                          (reg_addr == APR_STAT_ADDR) ? stat_word : 8'h00;

  // Control and status registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      audio_port_control <= APR_CTRL_RESET;
      ovf_sticky         <= 1'b0;
      reg_rdata          <= 8'h00;
      evt_last           <= 5'h00;
    end else begin
      if (ctrl_wr) begin
        audio_port_control <= reg_wdata;
      end
      ovf_sticky <= ovf_seen || (ovf_sticky && !ovf_clr);
      reg_rdata  <= reg_rd ? next_rdata : 8'h00;
      evt_last   <= evt_sync;
    end
  end

  // Halt watchdogs on bit and master clock frames
  genvar gh;
  generate
    for (gh = 0; gh < 2; gh++) begin : g_halt
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          halt_cnt[gh] <= 12'h000;
          halted[gh]   <= 1'b1;
        end else if (seen[gh]) begin
          halt_cnt[gh] <= 12'h000;
          halted[gh]   <= 1'b0;
        end else if (halt_cnt[gh] == 12'(HALT_CYC)) begin
          halted[gh]   <= 1'b1;
        end else begin
          halt_cnt[gh] <= halt_cnt[gh] + 12'h001;
        end
      end
    end
  endgenerate

  // Health state: mute while any clock is bad, resume when all good
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      health <= HEALTH_MUTED;
    end else begin
      unique case (health)
        HEALTH_MUTED: begin
          if (clocks_good) health <= HEALTH_PLAY;
        end
        HEALTH_PLAY: begin
          if (!clocks_good) health <= HEALTH_MUTED;
        end
      endcase
    end
  end
  assign channels_hiz = (health == HEALTH_MUTED);

  // Output stage fed from the FIFO
  logic         f_rd_valid;
  apr_word_type f_rd_data;
  wire          pop = f_rd_valid && sample_ready;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sample       <= '0;
      sample_valid <= 1'b0;
    end else begin
      if (pop) begin
        sample <= f_rd_data;
      end
      sample_valid <= pop && (health == HEALTH_PLAY);
    end
  end

  // ---------------- Bit clock domain ----------------
  logic [7:0]            cfg_b;
  logic                  fs_q;
  logic                  fs_last;
  logic [4:0]            bitn;
  logic [1:0]            wordn;
  logic [8:0]            frame_cnt;
  logic [APR_LANES-1:0][23:0] shreg;
  logic                  f_wr_ready;

  // Control word is quasi-static, carried by a plain synchroniser
  apr_sync #(.W(8)) u_cfg_sync (
    .clk    (bit_clk),
    .arst_n (arst_n),
    .d      (audio_port_control),
    .q      (cfg_b)
  );

  // Framing decode
  wire apr_fmt_type fmt = apr_fmt_type'(cfg_b[APR_FMT_LSB +: 2]);
  wire       len24   = cfg_b[APR_LEN24_BIT];
  wire [4:0] width   = len24 ? APR_LEN_LONG : APR_LEN_SHORT;
  wire [1:0] din     = {serial_data_in_two, serial_data_in_one};
  wire       delayed = (fmt == FMT_STANDARD) || (fmt == FMT_TDM);
  wire       eff_fs  = delayed ? fs_q : frame_sync;
  wire [1:0] eff_d   = din; // Only the sync is delayed, data never
  wire       fs_edge = eff_fs ^ fs_last;
  wire       fs_rise = eff_fs && !fs_last;
  wire       start   = (fmt == FMT_TDM) ? fs_rise : fs_edge;
  wire [4:0] cb      = start ? 5'h00 : bitn;
  wire [1:0] cw      = start ? 2'h0 : wordn;
  wire       word_end = (cb == width - 5'h01);
  wire       in_word = (fmt == FMT_TDM) ? (cw < 2'h2) : (cw == 2'h0);
  wire       shift_en = (fmt == FMT_RIGHT) || in_word;
  wire       emit_rj = (fmt == FMT_RIGHT) && fs_edge;
  wire       emit_fr = (fmt != FMT_RIGHT) && in_word && word_end;
  wire       emit    = emit_rj || emit_fr;

  // Channel tag per framing polarity
  wire right_tag = (fmt == FMT_STANDARD) ? eff_fs :
                   (fmt == FMT_LEFT)     ? !eff_fs :
                   (fmt == FMT_RIGHT)    ? !fs_last : cw[0];

  // Assembled word per lane
  apr_word_type wr_word;
  genvar gl;
  generate
    for (gl = 0; gl < APR_LANES; gl++) begin : g_lane
      wire [23:0] full_w = emit_rj ? shreg[gl] : {shreg[gl][22:0], eff_d[gl]};
      assign wr_word.data[gl] = sext(full_w, len24);

      // Serial to parallel, MSB first on rising edges
      always_ff @(posedge bit_clk or negedge arst_n) begin
        if (!arst_n) begin
          shreg[gl] <= 24'h000000;
        end else if (shift_en) begin
          shreg[gl] <= {shreg[gl][22:0], eff_d[gl]};
        end
      end
    end
  endgenerate
  assign wr_word.right = right_tag;

  // Input delay line and bit counters
  always_ff @(posedge bit_clk or negedge arst_n) begin
    if (!arst_n) begin
      fs_q    <= 1'b0;
      fs_last <= 1'b0;
      bitn    <= 5'h00;
      wordn   <= 2'h3;
    end else begin
      fs_q    <= frame_sync;
      fs_last <= eff_fs;
      if (word_end) begin
        bitn  <= 5'h00;
        wordn <= (cw == 2'h3) ? 2'h3 : cw + 2'h1;
      end else begin
        bitn  <= cb + 5'h01;
        wordn <= cw;
      end
    end
  end

  // Bit clocks per frame check
  wire [8:0] fc_end = frame_cnt + 9'h001;
  wire bpf_ok = (fmt == FMT_TDM) ?
                (fc_end == APR_BPF_TDM_LO || fc_end == APR_BPF_TDM_HI) :
                (fc_end == APR_BPF_LO || fc_end == APR_BPF_HI);

  always_ff @(posedge bit_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_cnt <= 9'h000;
      bclk_ok   <= 1'b0;
      frame_tgl <= 1'b0;
      ovf_tgl   <= 1'b0;
    end else begin
      if (fs_rise) begin
        frame_cnt <= 9'h000;
        bclk_ok   <= bpf_ok;
        frame_tgl <= !frame_tgl;
      end else if (frame_cnt != 9'h1FF) begin
        frame_cnt <= fc_end;
      end
      if (emit && !f_wr_ready) begin
        ovf_tgl <= !ovf_tgl;
      end
    end
  end

  // Sample FIFO, deep enough for the latency ceiling
  apr_fifo #(.W(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .wr_clk   (bit_clk),
    .rd_clk   (clk),
    .arst_n   (arst_n),
    .wr_valid (emit),
    .wr_ready (f_wr_ready),
    .wr_data  (wr_word),
    .rd_valid (f_rd_valid),
    .rd_ready (sample_ready),
    .rd_data  (f_rd_data)
  );

  // ---------------- Master clock domain ----------------
  logic       fs_m;
  logic       fs_m_last;
  logic [9:0] mcnt;

  apr_sync #(.W(1)) u_fs_msync (
    .clk    (master_clk),
    .arst_n (arst_n),
    .d      (frame_sync),
    .q      (fs_m)
  );

  wire [9:0] mc_end = mcnt + 10'h001;
  wire mpf_ok = (mc_end == APR_MPF_A) || (mc_end == APR_MPF_B) ||
                (mc_end == APR_MPF_C);

  // Master clocks per frame check
  always_ff @(posedge master_clk or negedge arst_n) begin
    if (!arst_n) begin
      fs_m_last  <= 1'b0;
      mcnt       <= 10'h000;
      mclk_ok    <= 1'b0;
      mframe_tgl <= 1'b0;
    end else begin
      fs_m_last <= fs_m;
      if (fs_m && !fs_m_last) begin
        mcnt       <= 10'h000;
        mclk_ok    <= mpf_ok;
        mframe_tgl <= !mframe_tgl;
      end else if (mcnt != 10'h3FF) begin
        mcnt <= mc_end;
      end
    end
  end

  // ---------------- Checks ----------------
  ctrl_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl_wr |=> audio_port_control == $past(reg_wdata))
    else $error("control register missed a write");

  strobe_cause_a: assert property (@(posedge clk) disable iff (!arst_n)
    sample_valid |-> $past(pop) && !$past(channels_hiz))
    else $error("sample strobe without a pop");

  hiz_mute_a: assert property (@(posedge clk) disable iff (!arst_n)
    $past(channels_hiz) |-> !sample_valid)
    else $error("sample delivered while muted");

  halt_force_a: assert property (@(posedge clk) disable iff (!arst_n)
    (halt_cnt[0] == 12'(HALT_CYC)) && !seen[0] |-> ##[1:2] channels_hiz)
    else $error("halted bit clock not muted");

  std_polarity_a: assert property (@(posedge bit_clk) disable iff (!arst_n)
    emit && fmt == FMT_STANDARD |-> wr_word.right == $past(frame_sync))
    else $error("standard channel tag wrong");

  lj_polarity_a: assert property (@(posedge bit_clk) disable iff (!arst_n)
    emit && fmt == FMT_LEFT |-> wr_word.right == !frame_sync)
    else $error("left-justified channel tag wrong");

  std_skip_a: assert property (@(posedge bit_clk) disable iff (!arst_n)
    fmt == FMT_STANDARD && start && $stable(cfg_b) |->
      $past(frame_sync) != $past(frame_sync, 2) ##1
      shreg[0][0] == $past(serial_data_in_one))
    else $error("standard first bit not skipped");

  lj_nodelay_a: assert property (@(posedge bit_clk) disable iff (!arst_n)
    fmt == FMT_LEFT && start && $stable(cfg_b) |=>
      shreg[0][0] == $past(serial_data_in_one))
    else $error("left-justified msb not taken at sync edge");

  pad_ignore_a: assert property (@(posedge bit_clk) disable iff (!arst_n)
    fmt != FMT_RIGHT && !in_word |=> $stable(shreg))
    else $error("padding bits shifted in");

  ratio_bad_a: assert property (@(posedge bit_clk) disable iff (!arst_n)
    fs_rise && !bpf_ok |=> !bclk_ok)
    else $error("bad bit clock ratio accepted");

endmodule

// File: testbench/apr_source.sv
// Audio source model: master clock, bit clock, frame sync, two lanes
`timescale 1ns/1ps
module apr_source
  import apr_pkg::*;
(
  output logic master_clk,
  output logic bit_clk,
  output logic frame_sync,
  output logic serial_data_in_one,
  output logic serial_data_in_two
);
  logic [23:0] q[$]; // Left one, left two, right one, right two

  // Idle lines, then a few clocks so reset sees link edges
  initial begin
    master_clk = 1'b0;
    bit_clk = 1'b0;
    repeat (4) bit_out(1'b0, 1'b0, 1'b0, 2);
  end

  // One bit period; lines change while the bit clock is low
  task automatic bit_out(input logic fs, input logic a, input logic b,
                         input int mpb);
    real hp;
    hp = 7.5 / mpb;
    frame_sync = fs;
    serial_data_in_one = a;
    serial_data_in_two = b;
    for (int m = 0; m < 2 * mpb; m++) begin
      #(hp) master_clk = ~master_clk;
      if (m == mpb - 1) bit_clk = 1'b1;
    end
    bit_clk = 1'b0;
  endtask

  // Warm-up zero frames, queued data frames, tail zero frames
  task automatic play(input apr_fmt_type fmt, input logic l24,
                      input int bpf, input int mpb, input int warm,
                      input int tail);
    logic [23:0] w[4];
    int          len;
    int          nd;
    int          pos;
    int          s;
    logic        fs;
    len = l24 ? 24 : 16;
    nd = q.size() / 4;
    for (int f = 0; f < warm + nd + tail; f++) begin
      for (int i = 0; i < 4; i++) begin
        w[i] = (f >= warm && f < warm + nd) ? q.pop_front() : 24'h000000;
      end
      for (int j = 0; j < bpf; j++) begin
        pos = (j % (bpf / 2)) - ((fmt == FMT_STANDARD) ? 1 : 0);
        fs = (j >= bpf / 2) ^ (fmt != FMT_STANDARD);
        s = (j >= bpf / 2) ? 2 : 0;
        // Right-justified: word ends at the sync edge
        if (fmt == FMT_RIGHT) pos = pos - bpf / 2 + len;
        // Multiplexed: one-bit sync pulse, then left and right slots
        if (fmt == FMT_TDM) begin
          fs = (j == 0);
          pos = (j == 0) ? -1 : (j - 1) % len;
          s = (j == 0) ? 0 : 2 * ((j - 1) / len);
        end
        if (pos >= 0 && pos < len && s < 4) begin
          bit_out(fs, w[s][len-1-pos], w[s+1][len-1-pos], mpb);
        end else begin
          bit_out(fs, 1'b0, 1'b0, mpb);
        end
      end
    end
    // Lines released: show inverse of last value
    serial_data_in_one = ~serial_data_in_one;
    serial_data_in_two = ~serial_data_in_two;
  endtask
endmodule

// File: testbench/tb_top.sv
// Testbench of the audio port receiver
`timescale 1ns/1ps
module tb_top
  import apr_pkg::*;
;
  localparam int HALT = 200;
  logic         clk;
  logic         arst_n;
  logic         bit_clk;
  logic         master_clk;
  logic         frame_sync;
  logic         sd_one;
  logic         sd_two;
  logic [7:0]   reg_addr;
  logic [7:0]   reg_wdata;
  logic         reg_wr;
  logic         reg_rd;
  logic [7:0]   reg_rdata;
  apr_word_type sample;
  logic         sample_valid;
  logic         sample_ready;
  logic         channels_hiz;
  logic [7:0]   rd;
  int           fail_count;
  int           check_count;
  apr_word_type expq[$];
  apr_word_type got[$];

  apr_receiver #(.FIFO_DEPTH(16), .HALT_CYC(HALT)) u_apr_receiver (
    .clk(clk), .arst_n(arst_n), .bit_clk(bit_clk), .master_clk(master_clk),
    .frame_sync(frame_sync), .serial_data_in_one(sd_one),
    .serial_data_in_two(sd_two), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample(sample), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .channels_hiz(channels_hiz));

  apr_source u_src (.master_clk(master_clk), .bit_clk(bit_clk),
    .frame_sync(frame_sync), .serial_data_in_one(sd_one),
    .serial_data_in_two(sd_two));

  // Clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // Collect delivered words, all-zero filler words left out
  always @(negedge clk) begin
    if (sample_valid === 1'b1 && sample.data !== '0) got.push_back(sample);
  end

  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cmpw(input string n, input apr_word_type e,
                      input apr_word_type s);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
    @(negedge clk);
  endtask

  // Wait, bounded, for the mute flag to reach a level, then judge it
  task automatic wait_hiz(input logic v, input int lim);
    for (int i = 0; i < lim && channels_hiz !== v; i++) @(negedge clk);
    cmp8("channels_hiz", {7'h00, v}, {7'h00, channels_hiz});
  endtask

  function automatic logic [23:0] ext(input logic [23:0] v, input logic l);
    return l ? v : {{8{v[15]}}, v[15:0]};
  endfunction

  // Queue n frames at the source and the words expected back
  task automatic load(input int n, input logic l);
    logic [23:0] v[4];
    logic [23:0] a;
    logic [23:0] b;
    v = '{24'h812345, 24'h7FEDCB, 24'hFF8001, 24'h00ABCD};
    for (int i = 0; i < n; i++) begin
      a = v[i % 4];
      b = v[(i + 1) % 4];
      u_src.q.push_back(a);
      u_src.q.push_back(~a);
      u_src.q.push_back(b);
      u_src.q.push_back(b ^ 24'h5A5A5A);
      expq.push_back('{right: 1'b0, data: {ext(~a, l), ext(a, l)}});
      expq.push_back('{right: 1'b1, data: {ext(b ^ 24'h5A5A5A, l), ext(b, l)}});
    end
  endtask

  // Play a stream in one framing and compare every delivered word
  task automatic stream(input apr_fmt_type f, input logic l, input int bpf,
                        input int mpb, input int n);
    reg_write(APR_CTRL_ADDR, {5'h00, l, f});
    expq.delete();
    got.delete();
    load(n, l);
    u_src.play(f, l, bpf, mpb, 4, 2);
    wait_hiz(1'b1, 2 * HALT);
    cmp8("word count", 8'(2 * n), 8'(got.size()));
    for (int i = 0; i < got.size() && i < expq.size(); i++) begin
      cmpw("sample", expq[i], got[i]);
    end
  endtask

  task automatic t_regs();
    cmp8("hiz after reset", 8'h01, {7'h00, channels_hiz});
    reg_read(APR_CTRL_ADDR, rd);
    cmp8("ctrl reset", APR_CTRL_RESET, rd);
    reg_write(APR_CTRL_ADDR, 8'hA7);
    reg_read(APR_CTRL_ADDR, rd);
    cmp8("ctrl write", 8'hA7, rd);
    reg_write(8'h20, 8'h55);
    reg_read(8'h20, rd);
    cmp8("unmapped", 8'h00, rd);
    reg_read(APR_CTRL_ADDR, rd);
    cmp8("ctrl kept", 8'hA7, rd);
    $display("test regs done");
  endtask

  task automatic t_standard();
    stream(FMT_STANDARD, 1'b1, 64, 2, 4);
    stream(FMT_STANDARD, 1'b0, 64, 4, 3);
    reg_read(APR_STAT_ADDR, rd);
    cmp8("play bit", 8'h00, {7'h00, rd[APR_ST_PLAY]});
    $display("test standard done");
  endtask

  task automatic t_left();
    stream(FMT_LEFT, 1'b0, 32, 4, 4);
    stream(FMT_LEFT, 1'b1, 64, 8, 3);
    $display("test left done");
  endtask

  // Right-justified and multiplexed framings
  task automatic t_right_tdm();
    stream(FMT_RIGHT, 1'b1, 64, 2, 3);
    stream(FMT_TDM, 1'b0, 128, 1, 3);
    $display("test right tdm done");
  endtask

  // Bad ratio mutes, good clocks restore, a halt mutes again
  task automatic t_bad_ratio();
    reg_write(APR_CTRL_ADDR, 8'h04);
    fork
      begin
        u_src.play(FMT_STANDARD, 1'b1, 64, 2, 5, 0);
        u_src.play(FMT_STANDARD, 1'b1, 48, 2, 6, 0);
        u_src.play(FMT_STANDARD, 1'b1, 64, 2, 6, 0);
      end
      begin
        wait_hiz(1'b0, 300);
        wait_hiz(1'b1, 400);
        wait_hiz(1'b0, 400);
      end
    join
    wait_hiz(1'b1, 2 * HALT);
    $display("test bad ratio done");
  endtask

  // Stall the consumer until the FIFO overflows, then drain it
  task automatic t_fifo();
    reg_write(APR_CTRL_ADDR, 8'h04);
    expq.delete();
    got.delete();
    load(12, 1'b1);
    fork
      u_src.play(FMT_STANDARD, 1'b1, 64, 2, 4, 8);
      begin
        wait_hiz(1'b0, 300);
        sample_ready = 1'b0;
        for (int i = 0; i < 2000 && u_src.q.size() != 0; i++) @(negedge clk);
        repeat (60) @(negedge clk);
        reg_read(APR_STAT_ADDR, rd);
        cmp8("overflow", 8'h01, {7'h00, rd[APR_ST_OVF]});
        sample_ready = 1'b1;
      end
    join
    wait_hiz(1'b1, 2 * HALT);
    cmp8("kept words ok", 8'h01, {7'h00, got.size() inside {[1:16]}});
    for (int i = 0; i < got.size(); i++) cmpw("fifo word", expq[i], got[i]);
    reg_write(APR_STAT_ADDR, 8'h02);
    reg_read(APR_STAT_ADDR, rd);
    cmp8("overflow clear", 8'h00, {7'h00, rd[APR_ST_OVF]});
    $display("test fifo done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    fail_count = 0;
    check_count = 0;
    arst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sample_ready = 1'b1;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    t_regs();
    t_standard();
    t_left();
    t_right_tdm();
    t_bad_ratio();
    t_fifo();
    end_of_test();
  end

  // Watchdog
  initial begin
    #600us;
    fail_count++;
    $display("mismatch watchdog expected done seen timeout");
    end_of_test();
  end
endmodule
